// *** hw/eeprom_serial_if.sv ***
// Serial EEPROM command interface: decoder, programming engine and array
`timescale 1ns/1ps
`default_nettype none
module eeprom_serial_if
    import eeprom_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES,
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic chip_select_i,
    input wire logic shift_clock_in_i,
    input wire logic serial_in_i,
    input wire logic word_width_select_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o
);
    localparam int CNT_W = $clog2(PROG_CYCLES_P + 1);
    localparam int PTR_W = (FIFO_DEPTH_P > 1) ? $clog2(FIFO_DEPTH_P) : 1;
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(PROG_CYCLES_P - 1);
    localparam logic [PTR_W:0] FIFO_FULL = (PTR_W + 1)'(FIFO_DEPTH_P);
    localparam logic [WIDX_W-1:0] FILL_END = WIDX_W'(WORDS_X16 - 1);

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic sk_prev_ff;
    logic cs_prev_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 4'h0;
            sync_ff <= 4'h0;
            sk_prev_ff <= 1'b0;
            cs_prev_ff <= 1'b0;
        end else if (ce_i) begin
            meta_ff <= {chip_select_i, shift_clock_in_i, serial_in_i, word_width_select_i};
            sync_ff <= meta_ff;
            sk_prev_ff <= sync_ff[2];
            cs_prev_ff <= sync_ff[3];
        end
    end
    wire cs_s = sync_ff[3];
    wire di_s = sync_ff[1];
    wire org_s = sync_ff[0];
    wire sk_rise = sync_ff[2] & ~sk_prev_ff;
    wire cs_rise = cs_s & ~cs_prev_ff;
    wire shift_en = cs_s & sk_rise;

    // ************************************************
    // Receiver decode
    // ************************************************
    rx_state_t st_ff;
    logic [4:0] cnt_ff;
    logic [1:0] opc_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] data_ff;
    logic [DATA_W-1:0] rd_sh_ff;
    logic wen_ff;
    logic push_pend_ff;
    logic [FIFO_W-1:0] pend_ff;
    logic status_ff;
    logic status_arm_ff;
    logic [DATA_W-1:0] mem_ff [WORDS_X16];

    wire [ADDR_W-1:0] addr_next = {addr_ff[ADDR_W-2:0], di_s};
    // Word mode ignores the top address bit
    wire [ADDR_W-1:0] addr_eff = org_s ? {1'b0, addr_next[5:0]} : addr_next;
    wire [1:0] ext_sel = org_s ? addr_next[5:4] : addr_next[6:5];
    wire [DATA_W-1:0] data_next = {data_ff[DATA_W-2:0], di_s};
    wire [4:0] addr_last = org_s ? ADDR_LAST_X16 : ADDR_LAST_X8;
    wire [4:0] data_last = org_s ? DATA_LAST_X16 : DATA_LAST_X8;
    wire [4:0] out_bits = org_s ? OUT_BITS_X16 : OUT_BITS_X8;
    wire start_ok = shift_en && st_ff == RX_IDLE && di_s && !push_pend_ff;
    wire addr_done = shift_en && st_ff == RX_ADDR && cnt_ff == 5'h00;
    wire data_done = shift_en && st_ff == RX_DATA && cnt_ff == 5'h00;
    wire is_ext = opc_ff == OPC_EXT;
    wire rd_cmd = addr_done && opc_ff == OPC_READ;
    wire wr_cmd = addr_done && opc_ff == OPC_WRITE;
    wire er_cmd = addr_done && opc_ff == OPC_ERASE;
    wire en_cmd = addr_done && is_ext && ext_sel == EXT_ENABLE;
    wire dis_cmd = addr_done && is_ext && ext_sel == EXT_DISABLE;
    wire erase_all_cmd_cmd = addr_done && is_ext && ext_sel == EXT_ERASE_ALL;
    wire write_all_cmd_cmd = addr_done && is_ext && ext_sel == EXT_WRITE_ALL;
    wire read_shift = shift_en && st_ff == RX_READ;
    wire push_req = wen_ff && (er_cmd || erase_all_cmd_cmd || data_done);
    wire prog_kind_t push_kind = er_cmd ? PK_ERASE : erase_all_cmd_cmd ? PK_ERASE_ALL :
        (opc_ff == OPC_WRITE) ? PK_WRITE : PK_WRITE_ALL;
    wire [ADDR_W-1:0] push_addr = er_cmd ? addr_eff : addr_ff;

    // Read word, byte lane picked by address bit 0
    wire [WIDX_W-1:0] rd_idx = org_s ? addr_next[5:0] : addr_next[6:1];
    wire [DATA_W-1:0] rd_word = mem_ff[rd_idx];
    wire [7:0] rd_byte = addr_next[0] ? rd_word[15:8] : rd_word[7:0];
    wire [DATA_W-1:0] rd_load = org_s ? rd_word : {rd_byte, EMPTY_BYTE};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= RX_IDLE;
            cnt_ff <= 5'h00;
            opc_ff <= 2'h0;
            addr_ff <= 7'h00;
            data_ff <= 16'h0000;
            rd_sh_ff <= 16'h0000;
        end else if (ce_i) begin
            if (!cs_s) begin
                st_ff <= RX_IDLE;
            end else if (shift_en) begin
                case (st_ff)
                    RX_IDLE: begin
                        if (start_ok) begin
                            st_ff <= RX_OPC;
                            cnt_ff <= OPC_LAST;
                        end
                    end
                    RX_OPC: begin
                        opc_ff <= {opc_ff[0], di_s};
                        if (cnt_ff == 5'h00) begin
                            st_ff <= RX_ADDR;
                            cnt_ff <= addr_last;
                        end else begin
                            cnt_ff <= cnt_ff - 5'h01;
                        end
                    end
                    RX_ADDR: begin
                        if (cnt_ff == 5'h00) begin
                            addr_ff <= addr_eff;
                            if (rd_cmd) begin
                                st_ff <= RX_READ;
                                rd_sh_ff <= rd_load;
                                cnt_ff <= out_bits;
                            end else if (wr_cmd || write_all_cmd_cmd) begin
                                st_ff <= RX_DATA;
                                cnt_ff <= data_last;
                            end else begin
                                st_ff <= RX_DONE;
                            end
                        end else begin
                            addr_ff <= addr_next;
                            cnt_ff <= cnt_ff - 5'h01;
                        end
                    end
                    RX_DATA: begin
                        data_ff <= data_next;
                        if (cnt_ff == 5'h00) begin
                            st_ff <= RX_DONE;
                        end else begin
                            cnt_ff <= cnt_ff - 5'h01;
                        end
                    end
                    RX_READ: begin
                        rd_sh_ff <= {rd_sh_ff[DATA_W-2:0], 1'b0};
                        cnt_ff <= cnt_ff - 5'h01;
                        if (cnt_ff == OUT_LAST) begin
                            st_ff <= RX_DONE;
                        end
                    end
                    RX_DONE: begin
                        st_ff <= RX_DONE;
                    end
                    default: begin
                        st_ff <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Programming enable: cleared by reset, standing in for power-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wen_ff <= 1'b0;
        end else if (ce_i) begin
            if (en_cmd) begin
                wen_ff <= 1'b1;
            end else if (dis_cmd) begin
                wen_ff <= 1'b0;
            end
        end
    end

    // ************************************************
    // Programming queue
    // ************************************************
    logic [FIFO_W-1:0] fifo_ff [FIFO_DEPTH_P];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] fill_cnt_ff;
    eng_state_t eng_ff;
    wire fifo_ready = fill_cnt_ff != FIFO_FULL;
    wire fifo_valid = fill_cnt_ff != '0;
    // A full queue holds the pending entry; new start bits wait for it
    wire fifo_push = push_pend_ff && fifo_ready;
    wire fifo_pop = fifo_valid && eng_ff == ENG_IDLE;
    wire [FIFO_W-1:0] head = fifo_ff[rd_ptr_ff];
    wire [PTR_W-1:0] wr_ptr_inc = (wr_ptr_ff == PTR_W'(FIFO_DEPTH_P - 1)) ? '0 : wr_ptr_ff + 1'b1;
    wire [PTR_W-1:0] rd_ptr_inc = (rd_ptr_ff == PTR_W'(FIFO_DEPTH_P - 1)) ? '0 : rd_ptr_ff + 1'b1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            push_pend_ff <= 1'b0;
            pend_ff <= '0;
        end else if (ce_i) begin
            if (push_req) begin
                push_pend_ff <= 1'b1;
                pend_ff <= {push_kind, push_addr, data_next};
            end else if (fifo_push) begin
                push_pend_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            fill_cnt_ff <= '0;
        end else if (ce_i) begin
            if (fifo_push) begin
                wr_ptr_ff <= wr_ptr_inc;
            end
            if (fifo_pop) begin
                rd_ptr_ff <= rd_ptr_inc;
            end
            if (fifo_push && !fifo_pop) begin
                fill_cnt_ff <= fill_cnt_ff + 1'b1;
            end else if (fifo_pop && !fifo_push) begin
                fill_cnt_ff <= fill_cnt_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && fifo_push) begin
            fifo_ff[wr_ptr_ff] <= pend_ff;
        end
    end

    // ************************************************
    // Self-timed programming engine
    // ************************************************
    logic [CNT_W-1:0] eng_cnt_ff;
    logic [WIDX_W-1:0] fill_idx_ff;
    prog_kind_t eng_kind_ff;
    logic [DATA_W-1:0] eng_data_ff;
    wire prog_kind_t h_kind = prog_kind_t'(head[FIFO_W-1 -: KIND_W]);
    wire [ADDR_W-1:0] h_addr = head[DATA_W +: ADDR_W];
    wire [DATA_W-1:0] h_data = head[DATA_W-1:0];
    wire h_single = h_kind == PK_ERASE || h_kind == PK_WRITE;
    wire [WIDX_W-1:0] h_widx = org_s ? h_addr[5:0] : h_addr[6:1];
    wire [DATA_W-1:0] h_old = mem_ff[h_widx];
    wire [DATA_W-1:0] h_lane = (h_kind == PK_ERASE) ? ERASED_WORD : h_data;
    wire [DATA_W-1:0] h_word = org_s ? h_lane :
        (h_addr[0] ? {h_lane[7:0], h_old[7:0]} : {h_old[15:8], h_lane[7:0]});
    wire [DATA_W-1:0] fill_word = (eng_kind_ff == PK_ERASE_ALL) ? ERASED_WORD :
        (org_s ? eng_data_ff : {eng_data_ff[7:0], eng_data_ff[7:0]});
    wire filling = eng_ff == ENG_FILL;
    wire mem_we = (fifo_pop && h_single) || filling;
    wire [WIDX_W-1:0] mem_widx = filling ? fill_idx_ff : h_widx;
    wire [DATA_W-1:0] mem_wdata = filling ? fill_word : h_word;
    wire busy = eng_ff != ENG_IDLE || fifo_valid || push_pend_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng_ff <= ENG_IDLE;
            eng_cnt_ff <= '0;
            fill_idx_ff <= '0;
            eng_kind_ff <= PK_ERASE;
            eng_data_ff <= 16'h0000;
        end else if (ce_i) begin
            case (eng_ff)
                ENG_IDLE: begin
                    eng_cnt_ff <= '0;
                    fill_idx_ff <= '0;
                    if (fifo_pop) begin
                        eng_kind_ff <= h_kind;
                        eng_data_ff <= h_data;
                        eng_ff <= h_single ? ENG_WAIT : ENG_FILL;
                    end
                end
                ENG_FILL: begin
                    eng_cnt_ff <= eng_cnt_ff + 1'b1;
                    fill_idx_ff <= fill_idx_ff + 1'b1;
                    if (fill_idx_ff == FILL_END) begin
                        eng_ff <= ENG_WAIT;
                    end
                end
                ENG_WAIT: begin
                    // Counter stops at the last busy cycle so it never reaches the limit
                    if (eng_cnt_ff >= CNT_END) begin
                        eng_ff <= ENG_IDLE;
                        eng_cnt_ff <= '0;
                    end else begin
                        eng_cnt_ff <= eng_cnt_ff + 1'b1;
                    end
                end
                default: begin
                    eng_ff <= ENG_IDLE;
                end
            endcase
        end
    end

    // Array has no reset: contents survive rst_i
    always_ff @(posedge clk_i) begin
        if (ce_i && mem_we) begin
            mem_ff[mem_widx] <= mem_wdata;
        end
    end

    // ************************************************
    // Ready/busy status and output pin
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_arm_ff <= 1'b0;
            status_ff <= 1'b0;
        end else if (ce_i) begin
            if (push_req) begin
                status_arm_ff <= 1'b1;
            end else if (cs_rise || (!cs_s && !busy)) begin
                status_arm_ff <= 1'b0;
            end
            if (cs_rise && status_arm_ff && busy) begin
                status_ff <= 1'b1;
            end else if (!cs_s || start_ok) begin
                status_ff <= 1'b0;
            end
        end
    end

    logic serial_out_ff;
    logic oe_n_ff;
    wire read_drive = rd_cmd || st_ff == RX_READ || (st_ff == RX_DONE && opc_ff == OPC_READ);
    wire nxt_oe_n = !(cs_s && (status_ff || read_drive));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else if (ce_i) begin
            oe_n_ff <= nxt_oe_n;
            if (status_ff) begin
                serial_out_ff <= !busy;
            end else if (rd_cmd) begin
                serial_out_ff <= 1'b0;
            end else if (read_shift) begin
                serial_out_ff <= rd_sh_ff[DATA_W-1];
            end
        end
    end
    assign serial_out_o = serial_out_ff;
    assign serial_out_oe_n_o = oe_n_ff;

    // ************************************************
    // Assertions
    // ************************************************
    a_hiz_cs_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cs_s) |=> serial_out_oe_n_o) else $error("output driven with cs low");
    a_wen_powerup: assert property (@(posedge clk_i)
        rst_i |=> !wen_ff) else $error("programming enabled after reset");
    a_wen_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (wen_ff && !dis_cmd) |=> wen_ff) else $error("enable lost without disable");
    a_prog_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(push_pend_ff) |-> $past(wen_ff)) else $error("programming while disabled");
    a_start_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && st_ff == RX_IDLE && shift_en && !push_pend_ff)
        |=> ((st_ff == RX_OPC) == $past(di_s))) else $error("start bit misdecoded");
    a_cs_discard: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cs_s) |=> st_ff == RX_IDLE) else $error("instruction kept after cs fall");
    a_dummy_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_cmd) |=> (!serial_out_o && !serial_out_oe_n_o))
        else $error("dummy bit not zero");
    a_out_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        ($changed(serial_out_o) && $past(st_ff) == RX_READ && !$past(status_ff))
        |-> $past(read_shift)) else $error("read data changed off edge");
    a_status_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && status_ff) |=> (serial_out_o == !$past(busy))) else $error("bad status");
    a_status_late: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cs_rise && !busy) |=> !status_ff) else $error("status after finish");
    a_prog_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        eng_cnt_ff < CNT_W'(PROG_CYCLES_P)) else $error("programming overran");
endmodule // eeprom_serial_if
`default_nettype wire

// *** include/eeprom_pkg.sv ***
// Constants and types of the serial EEPROM command interface
package eeprom_pkg;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_MHZ = 100;
    localparam int TWP_US = 5000;
    localparam int PROG_CYCLES = TWP_US * CLK_MHZ;
    // ************************************************
    // Array geometry
    // ************************************************
    localparam int WORDS_X16 = 64;
    localparam int WORDS_X8 = 128;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    localparam int WIDX_W = 6;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] EMPTY_BYTE = 8'h00;
    // Last bit index of each input field, per organization; read output bit counts and their end value
    localparam logic [4:0] OPC_LAST = 5'h01;
    localparam logic [4:0] ADDR_LAST_X16 = 5'h05;
    localparam logic [4:0] ADDR_LAST_X8 = 5'h06;
    localparam logic [4:0] DATA_LAST_X16 = 5'h0F;
    localparam logic [4:0] DATA_LAST_X8 = 5'h07;
    localparam logic [4:0] OUT_BITS_X16 = 5'h10;
    localparam logic [4:0] OUT_BITS_X8 = 5'h08;
    localparam logic [4:0] OUT_LAST = 5'h01;
    // ************************************************
    // Opcodes and extended selectors
    // ************************************************
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] OPC_EXT = 2'h0;
    localparam logic [1:0] EXT_ENABLE = 2'h3;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    // ************************************************
    // Programming queue and state encodings
    // ************************************************
    localparam int FIFO_DEPTH = 2;
    localparam int KIND_W = 2;
    localparam int FIFO_W = KIND_W + ADDR_W + DATA_W;
    typedef enum logic [1:0] {PK_ERASE, PK_WRITE, PK_ERASE_ALL, PK_WRITE_ALL} prog_kind_t;
    typedef enum logic [2:0] {RX_IDLE, RX_OPC, RX_ADDR, RX_DATA, RX_READ, RX_DONE} rx_state_t;
    typedef enum logic [1:0] {ENG_IDLE, ENG_FILL, ENG_WAIT} eng_state_t;
endpackage

// *** verification/eeprom_host_model.sv ***
// Host controller model driving the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_model (
    input wire logic clk_i,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_n_i,
    output logic chip_select_o,
    output logic shift_clock_o,
    output logic serial_data_o
);
    logic [31:0] rd_ff;
    // Released output reads as the inverse of its last level, so a late drive shows up
    wire seen_out = serial_out_oe_n_i ? ~serial_out_i : serial_out_i;
    // Shift clock idles low between frames
    initial begin
        chip_select_o = 1'b0;
        shift_clock_o = 1'b0;
        serial_data_o = 1'b0;
        rd_ff = 32'h0;
    end
    // Shift clock of 16 clk; output sampled late in the high phase
    task automatic frame(input logic [31:0] bits, input int n);
        chip_select_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_o <= bits[i];
            repeat (8) @(posedge clk_i);
            shift_clock_o <= 1'b1;
            repeat (7) @(posedge clk_i);
            rd_ff <= {rd_ff[30:0], seen_out};
            @(posedge clk_i);
            shift_clock_o <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        chip_select_o <= 1'b0;
        // Released data line shows the inverse, never a stale value
        serial_data_o <= ~serial_data_o;
        repeat (30) @(posedge clk_i);
    endtask
    task automatic poll(output logic driven, output logic busy, output logic ready);
        chip_select_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        driven = ~serial_out_oe_n_i;
        busy = ~seen_out;
        for (int k = 0; k < 400 && seen_out !== 1'b1; k++) @(posedge clk_i);
        ready = (seen_out === 1'b1) && (serial_out_oe_n_i === 1'b0);
        chip_select_o <= 1'b0;
        repeat (30) @(posedge clk_i);
    endtask
endmodule // eeprom_host_model
`default_nettype wire

// *** verification/test_eeprom_serial_if.sv ***
// Self-checking bench of the serial EEPROM command interface
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_serial_if
    import eeprom_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic word_width_select = 1'b1;
    logic cs, sk, di, so, so_oe_n;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    // Short programming time keeps the run brief
    eeprom_serial_if #(.PROG_CYCLES_P(200), .FIFO_DEPTH_P(2)) eeprom_serial_if_inst (
        .clk_i(clk),
        .rst_i(rst),
        .ce_i(ce),
        .chip_select_i(cs),
        .shift_clock_in_i(sk),
        .serial_in_i(di),
        .word_width_select_i(word_width_select),
        .serial_out_o(so),
        .serial_out_oe_n_o(so_oe_n)
    );
    eeprom_host_model eeprom_host_model_inst (
        .clk_i(clk),
        .serial_out_i(so),
        .serial_out_oe_n_i(so_oe_n),
        .chip_select_o(cs),
        .shift_clock_o(sk),
        .serial_data_o(di)
    );
    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic test_done();
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic send(input logic [31:0] b, input int n);
        eeprom_host_model_inst.frame(b, n);
    endtask
    // Dummy bit sits just above the data word
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        logic [31:0] got;
        if (word_width_select) send({1'b1, OPC_READ, a[5:0], 16'h0000}, 25);
        else send({1'b1, OPC_READ, a, 8'h00}, 18);
        got = word_width_select ? {15'h0000, eeprom_host_model_inst.rd_ff[16:0]}
                  : {23'h000000, eeprom_host_model_inst.rd_ff[8:0]};
        check("read word", {16'h0000, exp}, got);
        check("output released", 32'h1, {31'h0, so_oe_n});
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        if (word_width_select) send({1'b1, OPC_WRITE, a[5:0], d}, 25);
        else send({1'b1, OPC_WRITE, a, d[7:0]}, 18);
    endtask
    task automatic ext(input logic [1:0] sel);
        if (word_width_select) send({1'b1, OPC_EXT, sel, 4'h0}, 9);
        else send({1'b1, OPC_EXT, sel, 5'h00}, 10);
    endtask
    task automatic status(input logic drv);
        logic d, b, r;
        eeprom_host_model_inst.poll(d, b, r);
        check("status driven", {31'h0, drv}, {31'h0, d});
        if (drv) begin
            check("busy first", 32'h1, {31'h0, b});
            check("ready later", 32'h1, {31'h0, r});
        end
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_locked();
        send({1'b1, OPC_ERASE, 6'h05}, 9);
        status(1'b0);
    endtask
    task automatic t_erase_all();
        ext(EXT_ENABLE);
        ext(EXT_ERASE_ALL);
        status(1'b1);
        rd(7'h05, 16'hFFFF);
        rd(7'h3F, 16'hFFFF);
    endtask
    task automatic t_write();
        wr(7'h05, 16'hA5C3);
        status(1'b1);
        rd(7'h05, 16'hA5C3);
        wr(7'h05, 16'h1234);
        repeat (300) @(posedge clk);
        status(1'b0);
        rd(7'h05, 16'h1234);
        // Frozen clock enable must hold the engine busy
        wr(7'h05, 16'h0F0F);
        ce <= 1'b0;
        repeat (300) @(posedge clk);
        ce <= 1'b1;
        status(1'b1);
        rd(7'h05, 16'h0F0F);
    endtask
    task automatic t_erase_wall();
        send({1'b1, OPC_ERASE, 6'h05}, 9);
        status(1'b1);
        rd(7'h05, 16'hFFFF);
        send({1'b1, OPC_EXT, EXT_WRITE_ALL, 4'h0, 16'h3C5A}, 25);
        status(1'b1);
        rd(7'h00, 16'h3C5A);
        rd(7'h3F, 16'h3C5A);
        send({1'b1, OPC_WRITE, 6'h05, 3'h7}, 12);
        rd(7'h05, 16'h3C5A);
    endtask
    task automatic t_bytes();
        word_width_select <= 1'b0;
        repeat (8) @(posedge clk);
        rd(7'h01, 16'h003C);
        rd(7'h00, 16'h005A);
        wr(7'h07, 16'h0081);
        status(1'b1);
        rd(7'h07, 16'h0081);
        rd(7'h06, 16'h005A);
        ext(EXT_DISABLE);
        wr(7'h07, 16'h0000);
        status(1'b0);
        rd(7'h07, 16'h0081);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_locked();
        t_erase_all();
        t_write();
        t_erase_wall();
        t_bytes();
        test_done();
    end
endmodule // test_eeprom_serial_if
`default_nettype wire
